// [hdl/wvo_consts.svh]
// Register offsets, field positions, reset values and timing counts of the waveform offset bank.
`ifndef WVO_CONSTS_SVH
`define WVO_CONSTS_SVH

`define WVO_ADDR_POS_SUSTAIN   8'h0E
`define WVO_ADDR_NEG_SUSTAIN   8'h0F
`define WVO_ADDR_BRAKE         8'h10
`define WVO_ADDR_A2V_CTRL      8'h11

`define WVO_RST_POS_SUSTAIN    8'h00
`define WVO_RST_NEG_SUSTAIN    8'h00
`define WVO_RST_BRAKE          8'h00
`define WVO_RST_PEAK_WINDOW    2'h1
`define WVO_RST_LOWPASS        2'h1
`define WVO_RST_PEAK_MS        8'h14

`define WVO_PEAK_LSB           2
`define WVO_PEAK_MSB           3
`define WVO_LPF_LSB            0
`define WVO_LPF_MSB            1

`define WVO_STEP_MS            5
`define WVO_CLK_PERIOD_NS      5
`define WVO_STEP_CYCLES        ((`WVO_STEP_MS * 1000000) / `WVO_CLK_PERIOD_NS)

`define WVO_PEAK_MS_BASE       8'h0A
`define WVO_LPF_HZ_0           8'h64
`define WVO_LPF_HZ_1           8'h7D
`define WVO_LPF_HZ_2           8'h96
`define WVO_LPF_HZ_3           8'hC8

`define WVO_LEN_MAX            16'hFFFF

`endif

// [hdl/wvo_pkg.sv]
// Types shared by the waveform offset bank.
package wvo_pkg;

	// Segment classes, one-hot.
	typedef enum logic [4:0] {
		WVO_SEG_IDLE      = 5'b00001,
		WVO_SEG_OVERDRIVE = 5'b00010,
		WVO_SEG_POS       = 5'b00100,
		WVO_SEG_NEG       = 5'b01000,
		WVO_SEG_BRAKE     = 5'b10000
	} wvo_seg_t;

	// One waveform segment as offered by the playback engine.
	typedef struct packed {
		logic signed [7:0] level;
		logic signed [7:0] wave_max;
		logic signed [7:0] wave_min;
		logic [15:0]       len;
	} wvo_seg_req_t;

	// Register access request; reads use addr only, writes also use wdata.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
	} wvo_reg_req_t;

endpackage

// [hdl/wvo_offset_bank.sv]
// Waveform timing offset registers, segment duration adjuster and audio_vibe_control.
//
// Contract
// - Positive sustain segment length changes by signed positive offset times 5 ms.
// - Any positive level not in overdrive counts as positive sustain.
// - Negative sustain segment length changes by signed negative offset times 5 ms.
// - Negative sustain offset is two's complement, extending or shortening.
// - Any negative level not in braking counts as negative sustain.
// - Braking segment length changes by signed brake offset times 5 ms.
// - Braking segment is the portion holding the most negative level.
// - Brake offset acts only in open loop; closed loop ignores it.
// - Peak window field bits 3-2 selects 10/20/30/40 ms, reset code 1.
// - Lowpass field bits 1-0 selects 100/125/150/200 Hz, reset code 1.
// - Overdrive segment is the portion holding the maximum level.
`timescale 1ns/1ps
`include "wvo_consts.svh"

module wvo_offset_bank #(
	parameter int STEP_CYCLES = `WVO_STEP_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire wvo_pkg::wvo_reg_req_t reg_req,
	output logic [7:0]                 reg_rdata,
	input  wire logic                  closed_loop,
	input  wire logic                  seg_valid,
	input  wire wvo_pkg::wvo_seg_req_t seg_req,
	output logic                       adj_valid,
	output wvo_pkg::wvo_seg_t          adj_class,
	output logic [15:0]                adj_len,
	output logic [35:0]                adj_cycles,
	output logic [1:0]                 a2v_peak_window,
	output logic [1:0]                 a2v_lowpass_select,
	output logic [7:0]                 a2v_peak_ms,
	output logic [7:0]                 a2v_lowpass_hz
);
	import wvo_pkg::*;

	logic [7:0]        pos_sustain_offset_r;
	logic [7:0]        neg_sustain_offset_r;
	logic [7:0]        brake_time_offset_r;
	logic [1:0]        peak_window_r;
	logic [1:0]        lowpass_r;
	wvo_seg_t          class_nxt;
	logic signed [7:0] offset_nxt;
	logic signed [17:0] sum_nxt;
	logic [15:0]       len_nxt;

	// Offset registers, written by the register port.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pos_sustain_offset_r <= `WVO_RST_POS_SUSTAIN;
			neg_sustain_offset_r <= `WVO_RST_NEG_SUSTAIN;
			brake_time_offset_r  <= `WVO_RST_BRAKE;
		end else if (reg_wr) begin
			if (reg_req.addr == `WVO_ADDR_POS_SUSTAIN) begin
				pos_sustain_offset_r <= reg_req.wdata;
			end
			if (reg_req.addr == `WVO_ADDR_NEG_SUSTAIN) begin
				neg_sustain_offset_r <= reg_req.wdata;
			end
			if (reg_req.addr == `WVO_ADDR_BRAKE) begin
				brake_time_offset_r <= reg_req.wdata;
			end
		end
	end

	// Audio_vibe_control fields; the upper nibble is not stored.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			peak_window_r <= `WVO_RST_PEAK_WINDOW;
			lowpass_r     <= `WVO_RST_LOWPASS;
		end else if (reg_wr && reg_req.addr == `WVO_ADDR_A2V_CTRL) begin
			peak_window_r <= reg_req.wdata[`WVO_PEAK_MSB:`WVO_PEAK_LSB];
			lowpass_r     <= reg_req.wdata[`WVO_LPF_MSB:`WVO_LPF_LSB];
		end
	end

	// Read data is registered; unmapped offsets and reserved bits read zero.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_req.addr)
				`WVO_ADDR_POS_SUSTAIN: reg_rdata <= pos_sustain_offset_r;
				`WVO_ADDR_NEG_SUSTAIN: reg_rdata <= neg_sustain_offset_r;
				`WVO_ADDR_BRAKE:       reg_rdata <= brake_time_offset_r;
				`WVO_ADDR_A2V_CTRL:    reg_rdata <= {4'h0, peak_window_r, lowpass_r};
				default:               reg_rdata <= 8'h00;
			endcase
		end
	end

	// Classify the offered segment and pick the offset that applies to it.
	always_comb begin
		class_nxt  = WVO_SEG_IDLE;
		offset_nxt = 8'sh00;
		if (seg_req.level == seg_req.wave_max && seg_req.level > 8'sh00) begin
			class_nxt = WVO_SEG_OVERDRIVE;
		end else if (seg_req.level == seg_req.wave_min && seg_req.level < 8'sh00) begin
			class_nxt = WVO_SEG_BRAKE;
			offset_nxt = closed_loop ? 8'sh00 : $signed(brake_time_offset_r);
		end else if (seg_req.level > 8'sh00) begin
			class_nxt  = WVO_SEG_POS;
			offset_nxt = $signed(pos_sustain_offset_r);
		end else if (seg_req.level < 8'sh00) begin
			class_nxt  = WVO_SEG_NEG;
			offset_nxt = $signed(neg_sustain_offset_r);
		end
	end

	// Signed sum of length and offset, clamped at zero and at full scale.
	always_comb begin
		sum_nxt = $signed({2'b00, seg_req.len}) + 18'(offset_nxt);
		if (sum_nxt < 18'sh00000) begin
			len_nxt = 16'h0000;
		end else if (sum_nxt > $signed({2'b00, `WVO_LEN_MAX})) begin
			len_nxt = `WVO_LEN_MAX;
		end else begin
			len_nxt = sum_nxt[15:0];
		end
	end

	// Adjusted segment result, one cycle after the request.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			adj_valid  <= 1'b0;
			adj_class  <= WVO_SEG_IDLE;
			adj_len    <= 16'h0000;
			adj_cycles <= 36'h000000000;
		end else begin
			adj_valid <= seg_valid;
			if (seg_valid) begin
				adj_class <= class_nxt;
				adj_len    <= len_nxt;
				adj_cycles <= 36'(len_nxt) * 36'(STEP_CYCLES);
			end
		end
	end

	// Decoded audio-to-vibe settings for the signal path.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			a2v_peak_window    <= `WVO_RST_PEAK_WINDOW;
			a2v_lowpass_select <= `WVO_RST_LOWPASS;
			a2v_peak_ms        <= `WVO_RST_PEAK_MS;
			a2v_lowpass_hz     <= `WVO_LPF_HZ_1;
		end else begin
			a2v_peak_window    <= peak_window_r;
			a2v_lowpass_select <= lowpass_r;
			// window of 10 ms per code step.
			a2v_peak_ms <= 8'(({6'h00, peak_window_r} + 8'h01) * `WVO_PEAK_MS_BASE);
			unique case (lowpass_r)
				2'h0: a2v_lowpass_hz <= `WVO_LPF_HZ_0;
				2'h1: a2v_lowpass_hz <= `WVO_LPF_HZ_1;
				2'h2: a2v_lowpass_hz <= `WVO_LPF_HZ_2;
				2'h3: a2v_lowpass_hz <= `WVO_LPF_HZ_3;
			endcase
		end
	end

	// Checks on the adjuster and control decode.
	a_pos_sustain: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && class_nxt == WVO_SEG_POS && seg_req.len >= 16'h0100 && seg_req.len <= 16'hFE00
		|=> adj_len == 16'($past(seg_req.len) + {{8{$past(pos_sustain_offset_r[7])}}, $past(pos_sustain_offset_r)}))
		else $error("positive sustain length wrong");
	a_pos_class: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && seg_req.level > 8'sh00 && seg_req.level != seg_req.wave_max |=> adj_class == WVO_SEG_POS)
		else $error("positive level misclassified");
	a_neg_sustain: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && class_nxt == WVO_SEG_NEG && seg_req.len >= 16'h0100 && seg_req.len <= 16'hFE00
		|=> adj_len == 16'($past(seg_req.len) + {{8{$past(neg_sustain_offset_r[7])}}, $past(neg_sustain_offset_r)}))
		else $error("negative sustain length wrong");
	a_neg_shorten: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && class_nxt == WVO_SEG_NEG && neg_sustain_offset_r[7] && seg_req.len > 16'h0080
		|=> adj_len < $past(seg_req.len))
		else $error("negative offset did not shorten");
	a_neg_class: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && seg_req.level < 8'sh00 && seg_req.level != seg_req.wave_min
		&& seg_req.level != seg_req.wave_max |=> adj_class == WVO_SEG_NEG)
		else $error("negative level misclassified");
	a_brake_open: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && class_nxt == WVO_SEG_BRAKE && !closed_loop && seg_req.len >= 16'h0100
		&& seg_req.len <= 16'hFE00
		|=> adj_len == 16'($past(seg_req.len) + {{8{$past(brake_time_offset_r[7])}}, $past(brake_time_offset_r)}))
		else $error("brake length wrong");
	a_brake_class: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && seg_req.level < 8'sh00 && seg_req.level == seg_req.wave_min |=> adj_class == WVO_SEG_BRAKE)
		else $error("brake segment misclassified");
	a_brake_closed: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && class_nxt == WVO_SEG_BRAKE && closed_loop |=> adj_len == $past(seg_req.len))
		else $error("brake offset applied in closed loop");
	a_peak_window: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_req.addr == `WVO_ADDR_A2V_CTRL
		|-> ##2 a2v_peak_ms == 8'h0A * (8'($past(reg_req.wdata[3:2], 2)) + 8'h01))
		else $error("peak window decode wrong");
	a_lowpass: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && reg_req.addr == `WVO_ADDR_A2V_CTRL && reg_req.wdata[1:0] == 2'h3 |-> ##2 a2v_lowpass_hz == 8'hC8)
		else $error("lowpass decode wrong");
	a_overdrive: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && seg_req.level > 8'sh00 && seg_req.level == seg_req.wave_max
		|=> adj_class == WVO_SEG_OVERDRIVE && adj_len == $past(seg_req.len))
		else $error("overdrive segment mishandled");
	a_clamp_zero: assert property (@(posedge clk) disable iff (!nrst)
		seg_valid && class_nxt == WVO_SEG_POS && pos_sustain_offset_r == 8'h80 && seg_req.len < 16'h0080
		|=> adj_len == 16'h0000)
		else $error("negative length not clamped");

	c_pos_seg: cover property (@(posedge clk) disable iff (!nrst) adj_valid && adj_class == WVO_SEG_POS);
	c_brake_open: cover property (@(posedge clk) disable iff (!nrst)
		seg_valid && class_nxt == WVO_SEG_BRAKE && !closed_loop);
	c_clamp: cover property (@(posedge clk) disable iff (!nrst) seg_valid && sum_nxt < 18'sh00000);
	c_a2v_write: cover property (@(posedge clk) disable iff (!nrst) reg_wr && reg_req.addr == `WVO_ADDR_A2V_CTRL);

endmodule

// [test/wvo_offset_bank_tb_top.sv]
// Self-checking testbench for the waveform offset bank.
`timescale 1ns/1ps
`include "wvo_consts.svh"

module wvo_offset_bank_tb_top;
	import wvo_pkg::*;

	localparam int STEPS = 4;

	logic         clk;
	logic         nrst;
	logic         reg_wr;
	logic         reg_rd;
	wvo_reg_req_t reg_req;
	logic [7:0]   reg_rdata;
	logic         closed_loop;
	logic         seg_valid;
	wvo_seg_req_t seg_req;
	logic         adj_valid;
	wvo_seg_t     adj_class;
	logic [15:0]  adj_len;
	logic [35:0]  adj_cycles;
	logic [1:0]   a2v_peak_window;
	logic [1:0]   a2v_lowpass_select;
	logic [7:0]   a2v_peak_ms;
	logic [7:0]   a2v_lowpass_hz;
	int           num_errors;
	int           total_checks;
	int           cycle_count;

	// A short step keeps the cycle counts small while keeping the scaling visible.
	wvo_offset_bank #(.STEP_CYCLES(STEPS)) wvo_offset_bank_i (
		.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.closed_loop(closed_loop), .seg_valid(seg_valid), .seg_req(seg_req), .adj_valid(adj_valid),
		.adj_class(adj_class), .adj_len(adj_len), .adj_cycles(adj_cycles), .a2v_peak_window(a2v_peak_window),
		.a2v_lowpass_select(a2v_lowpass_select), .a2v_peak_ms(a2v_peak_ms), .a2v_lowpass_hz(a2v_lowpass_hz)
	);

	// Clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	always @(posedge clk) begin
		cycle_count++;
		if (cycle_count == 3000) begin
			num_errors++;
			complete_run();
		end
	end

	// Compares a seen value with the expected one.
	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// One register write; an idle edge follows so the strobe is never reassigned in one step.
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		reg_wr  <= 1'b1;
		reg_req <= '{addr: addr, wdata: data};
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	// One register read; the data latched on the strobe edge is judged at the next edge, where it still holds.
	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		reg_rd  <= 1'b1;
		reg_req <= '{addr: addr, wdata: 8'h00};
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		check("reg_rdata", {28'h0, reg_rdata}, {28'h0, exp});
	endtask

	// Offers one segment and judges class, length, cycle count and the valid pulse.
	task automatic seg_run(input logic [7:0] lvl, input logic [7:0] mx, input logic [7:0] mn,
			input logic [15:0] len, input wvo_seg_t cls, input logic [15:0] exp_len);
		seg_valid <= 1'b1;
		seg_req   <= '{level: lvl, wave_max: mx, wave_min: mn, len: len};
		@(posedge clk);
		seg_valid <= 1'b0;
		// The result launched on the taking edge is judged at the next edge, before it is overwritten.
		@(posedge clk);
		check("adj_valid", {35'h0, adj_valid}, 36'h1);
		check("adj_class", {31'h0, adj_class}, {31'h0, cls});
		check("adj_len", {20'h0, adj_len}, {20'h0, exp_len});
		check("adj_cycles", adj_cycles, 36'(exp_len) * 36'(STEPS));
		@(posedge clk);
		check("adj_valid end", {35'h0, adj_valid}, 36'h0);
	endtask

	// Reset values of the registers and the decoded outputs.
	task automatic test_reset();
		check("peak_ms", {28'h0, a2v_peak_ms}, 36'd20);
		check("lowpass_hz", {28'h0, a2v_lowpass_hz}, 36'd125);
		reg_read(`WVO_ADDR_POS_SUSTAIN, 8'h00);
		reg_read(`WVO_ADDR_NEG_SUSTAIN, 8'h00);
		reg_read(`WVO_ADDR_BRAKE, 8'h00);
		reg_read(`WVO_ADDR_A2V_CTRL, 8'h05);
	endtask

	// Readback of the offsets and an unmapped write that must change nothing.
	task automatic test_regs();
		reg_write(`WVO_ADDR_POS_SUSTAIN, 8'h5A);
		reg_write(`WVO_ADDR_NEG_SUSTAIN, 8'hA5);
		reg_write(`WVO_ADDR_BRAKE, 8'hC3);
		reg_write(8'h12, 8'hAA);
		reg_read(`WVO_ADDR_POS_SUSTAIN, 8'h5A);
		reg_read(`WVO_ADDR_NEG_SUSTAIN, 8'hA5);
		reg_read(`WVO_ADDR_BRAKE, 8'hC3);
		reg_read(8'h12, 8'h00);
	endtask

	// Every code of both fields, with the reserved bits written high.
	task automatic test_a2v();
		logic [7:0] hz [4] = '{8'h64, 8'h7D, 8'h96, 8'hC8};
		for (int p = 0; p < 4; p++) begin
			reg_write(`WVO_ADDR_A2V_CTRL, 8'hF0 | 8'(p * 4 + 3 - p));
			repeat (2) @(posedge clk);
			check("peak_window", {34'h0, a2v_peak_window}, 36'(p));
			check("peak_ms", {28'h0, a2v_peak_ms}, 36'(10 * (p + 1)));
			check("lowpass_select", {34'h0, a2v_lowpass_select}, 36'(3 - p));
			check("lowpass_hz", {28'h0, a2v_lowpass_hz}, {28'h0, hz[3 - p]});
			reg_read(`WVO_ADDR_A2V_CTRL, 8'(p * 4 + 3 - p));
		end
	endtask

	// Classification and signed offsets, open and closed loop, clamp at zero.
	task automatic test_segments();
		reg_write(`WVO_ADDR_POS_SUSTAIN, 8'h03);
		reg_write(`WVO_ADDR_NEG_SUSTAIN, 8'hFE);
		reg_write(`WVO_ADDR_BRAKE, 8'h05);
		seg_run(8'h40, 8'h7F, 8'h80, 16'd300, WVO_SEG_POS, 16'd303);
		seg_run(8'h7F, 8'h7F, 8'h80, 16'd300, WVO_SEG_OVERDRIVE, 16'd300);
		seg_run(8'hF0, 8'h7F, 8'h80, 16'd300, WVO_SEG_NEG, 16'd298);
		seg_run(8'h80, 8'h7F, 8'h80, 16'd300, WVO_SEG_BRAKE, 16'd305);
		closed_loop <= 1'b1;
		seg_run(8'h80, 8'h7F, 8'h80, 16'd300, WVO_SEG_BRAKE, 16'd300);
		closed_loop <= 1'b0;
		seg_run(8'h00, 8'h7F, 8'h80, 16'd300, WVO_SEG_IDLE, 16'd300);
		reg_write(`WVO_ADDR_POS_SUSTAIN, 8'h80);
		reg_write(`WVO_ADDR_NEG_SUSTAIN, 8'h7F);
		seg_run(8'h40, 8'h7F, 8'h80, 16'd5, WVO_SEG_POS, 16'd0);
		seg_run(8'hF0, 8'h7F, 8'h80, 16'd10, WVO_SEG_NEG, 16'd137);
		seg_run(8'hF0, 8'h7F, 8'h80, 16'hFFF0, WVO_SEG_NEG, 16'hFFFF);
	endtask

	// Main sequence.
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_req = '0;
		closed_loop = 1'b0;
		seg_valid = 1'b0;
		seg_req = '0;
		num_errors = 0;
		total_checks = 0;
		cycle_count = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		test_reset();
		test_regs();
		test_a2v();
		test_segments();
		complete_run();
	end
endmodule
